// [include/cod_pkg.sv]
// Shared types and constants of the primary opcode decoder
package cod_pkg;

  // Escape byte that opens a two-byte opcode
  localparam logic [7:0] COD_PREFIX = 8'h30;

  // Idle forms and a few single-byte opcodes the decoder singles out
  localparam logic [7:0] COD_OP_IDLE_ONE = 8'h70;
  localparam logic [7:0] COD_OP_IDLE_TWO = 8'h73;
  localparam logic [7:0] COD_OP_IDLE_THREE = 8'h72;
  localparam logic [7:0] COD_OP_SUB_EXIT = 8'h78;
  localparam logic [7:0] COD_OP_TRANSLATED_MOVE = 8'h0C;
  localparam logic [7:0] COD_OP_WAIT = 8'h2F;
  localparam logic [7:0] COD_OP_QUICK_EXIT = 8'h98;

  // Second bytes of the two-byte opcodes
  localparam logic [7:0] COD_X_VERSION = 8'h09;
  localparam logic [7:0] COD_X_PIN_ON = 8'h0D;
  localparam logic [7:0] COD_X_PIN_OFF = 8'h13;
  localparam logic [7:0] COD_X_BLOCK_COPY = 8'h19;
  localparam logic [7:0] COD_X_STR_END = 8'h1F;
  localparam logic [7:0] COD_X_INT_ACK = 8'h2F;
  localparam logic [7:0] COD_X_STR_COPY = 8'h35;
  localparam logic [7:0] COD_X_GATE_EXIT = 8'h45;
  localparam logic [7:0] COD_X_GATE = 8'h61;
  localparam logic [7:0] COD_X_PROC_CALL = 8'hAC;
  localparam logic [7:0] COD_X_USER_PROC = 8'hC0;
  localparam logic [7:0] COD_X_PROC_RESUME = 8'hC8;

  // One bit per single-byte opcode, bit n set when opcode n is assigned
  localparam logic [255:0] COD_LEGAL_MAP =
    256'hDDDD_DDD9_D91D_DDD1_DDDD_DDD9_D9DD_DDDD_FDDD_FDDD_FDDD_FDDD_FDDD_FF9D_F399_FFDC;

  // Opcode bytes of a two-byte form, and of the idle forms
  localparam logic [1:0] COD_SPAN_ONE = 2'h1;
  localparam logic [1:0] COD_SPAN_TWO = 2'h2;
  localparam logic [1:0] COD_SPAN_THREE = 2'h3;

  typedef enum logic [3:0] {
    cls_illegal, cls_nop, cls_arith, cls_logic, cls_shift, cls_bcd, cls_branch,
    cls_ret_cond, cls_interlock, cls_coproc, cls_tdb, cls_move, cls_control, cls_system
  } cod_class_t;

  typedef enum logic [3:0] {
    cc_none, cc_always, cc_eq, cc_ne, cc_gt, cc_ge, cc_lt, cc_le, cc_gtu, cc_leu,
    cc_carry_clear, cc_carry_set, cc_ovf_clear, cc_ovf_set
  } cod_cond_t;

  // Codes follow the low opcode bits: word 0, halfword 2, byte 3
  typedef enum logic [1:0] {
    sz_word = 2'h0, sz_none = 2'h1, sz_half = 2'h2, sz_byte = 2'h3
  } cod_size_t;

  typedef enum logic [1:0] {disp_none, disp_byte, disp_half} cod_disp_t;

  typedef enum logic [6:0] {
    fn_none, fn_read_version_number, fn_virtual_pin_on_jump, fn_virtual_pin_off_jump,
    fn_block_word_copy, fn_string_terminator_find, fn_interrupt_acknowledge_op,
    fn_string_copy_op, fn_gate_exit, fn_gate_enter, fn_process_invoke,
    fn_user_process_invoke, fn_process_resume, fn_translated_word_move,
    fn_quick_interrupt_exit, fn_wait_interrupt, fn_compare_swap_locked,
    fn_word_exchange_locked, fn_coprocessor_generic_op, fn_cop_read, fn_cop_write,
    fn_cop_two_addr, fn_arith_left_shift_word, fn_arith_right_shift, fn_logical_left_shift,
    fn_logical_right_shift_word, fn_rotate_word_op, fn_insert_field, fn_extract_field,
    fn_decimal_add_three, fn_decimal_add_two, fn_decimal_subtract_three,
    fn_decimal_subtract_two, fn_decimal_compress, fn_decimal_expand, fn_count_test_branch,
    fn_count_down_branch, fn_conditional_branch, fn_conditional_exit, fn_jump_relative,
    fn_subroutine_exit, fn_subroutine_branch, fn_subroutine_call, fn_jump,
    fn_procedure_call, fn_procedure_return, fn_reg_save, fn_reg_restore, fn_x_flag,
    fn_extended, fn_cache_flush, fn_breakpoint, fn_idle, fn_clear, fn_move,
    fn_move_address, fn_push, fn_pop, fn_complement, fn_negate, fn_increment,
    fn_decrement, fn_add, fn_subtract, fn_multiply, fn_divide, fn_modulo, fn_or, fn_xor,
    fn_and, fn_test, fn_compare, fn_bit_test
  } cod_fn_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic priv;
    logic prefixed;
    logic three_addr;
    cod_class_t cls;
    cod_cond_t cond;
    cod_fn_t fn;
    cod_size_t size;
    cod_disp_t disp;
    logic [1:0] span;
    logic [15:0] opcode;
  } cod_dec_t;

endpackage : cod_pkg

// [core/cod_ext_decode.sv]
// Decoder for the second byte of an escaped two-byte opcode
`timescale 1ns/1ps
`default_nettype none
module cod_ext_decode
  import cod_pkg::*;
(
  input wire logic [7:0] second_byte,
  output cod_dec_t ext_dec
);

  always_comb begin
    ext_dec = '0;
    ext_dec.prefixed = 1'b1;
    ext_dec.opcode = {COD_PREFIX, second_byte};
    ext_dec.span = COD_SPAN_TWO;
    ext_dec.size = sz_none;
    ext_dec.cond = cc_none;
    ext_dec.disp = disp_none;
    ext_dec.cls = cls_system;
    ext_dec.priv = 1'b1;
    case (second_byte)
      COD_X_VERSION: begin
        ext_dec.fn = fn_read_version_number;
        ext_dec.priv = 1'b0;
        ext_dec.cls = cls_move;
      end
      COD_X_PIN_ON: ext_dec.fn = fn_virtual_pin_on_jump;
      COD_X_PIN_OFF: ext_dec.fn = fn_virtual_pin_off_jump;
      COD_X_BLOCK_COPY: begin
        ext_dec.fn = fn_block_word_copy;
        ext_dec.priv = 1'b0;
        ext_dec.cls = cls_move;
        ext_dec.size = sz_word;
      end
      COD_X_STR_END: begin
        ext_dec.fn = fn_string_terminator_find;
        ext_dec.priv = 1'b0;
        ext_dec.cls = cls_move;
      end
      COD_X_INT_ACK: ext_dec.fn = fn_interrupt_acknowledge_op;
      COD_X_STR_COPY: begin
        ext_dec.fn = fn_string_copy_op;
        ext_dec.priv = 1'b0;
        ext_dec.cls = cls_move;
      end
      COD_X_GATE_EXIT: ext_dec.fn = fn_gate_exit;
      COD_X_GATE: ext_dec.fn = fn_gate_enter;
      COD_X_PROC_CALL: ext_dec.fn = fn_process_invoke;
      COD_X_USER_PROC: ext_dec.fn = fn_user_process_invoke;
      COD_X_PROC_RESUME: ext_dec.fn = fn_process_resume;
      default: begin
        // Unassigned second byte reports as illegal and carries no privilege
        ext_dec.illegal = 1'b1;
        ext_dec.priv = 1'b0;
        ext_dec.cls = cls_illegal;
      end
    endcase
  end

endmodule : cod_ext_decode
`default_nettype wire

// [core/cod_decoder.sv]
// Primary opcode decoder: fetched opcode bytes in, decoded operation out
`timescale 1ns/1ps
`default_nettype none
module cod_decoder
  import cod_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  input wire logic fetch_flush,
  output cod_dec_t decode_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic cod_size_t size_of(input logic [7:0] op);
    case (op[1:0])
      2'h0: size_of = sz_word;
      2'h2: size_of = sz_half;
      2'h3: size_of = sz_byte;
      default: size_of = sz_none;
    endcase
  endfunction : size_of

  // Condition of returns and branches in 0x40..0x7F, indexed by opcode bits 5..2
  function automatic cod_cond_t cond_of(input logic [3:0] idx);
    case (idx)
      4'h0: cond_of = cc_ge;
      4'h1: cond_of = cc_gt;
      4'h2: cond_of = cc_lt;
      4'h3: cond_of = cc_le;
      4'h4: cond_of = cc_carry_clear;
      4'h5: cond_of = cc_gtu;
      4'h6: cond_of = cc_carry_set;
      4'h7: cond_of = cc_leu;
      4'h8: cond_of = cc_ovf_clear;
      4'h9: cond_of = cc_ne;
      4'hA: cond_of = cc_ovf_set;
      4'hB: cond_of = cc_eq;
      4'hD: cond_of = cc_ne;
      4'hE: cond_of = cc_always;
      4'hF: cond_of = cc_eq;
      default: cond_of = cc_none;
    endcase
  endfunction : cond_of

  // Test-decrement-branch condition, same order for byte and halfword forms
  function automatic cod_cond_t tdb_cond(input logic [1:0] idx);
    case (idx)
      2'h0: tdb_cond = cc_eq;
      2'h1: tdb_cond = cc_ge;
      2'h2: tdb_cond = cc_gt;
      default: tdb_cond = cc_ne;
    endcase
  endfunction : tdb_cond

  function automatic cod_dec_t decode_single(input logic [7:0] op);
    cod_dec_t d;
    d = '0;
    d.opcode = {8'h00, op};
    d.span = COD_SPAN_ONE;
    d.cls = cls_control;
    d.cond = cc_none;
    d.fn = fn_none;
    d.size = sz_none;
    d.disp = disp_none;
    if (op[7] && op[6] && op[5:2] < 4'h7) begin
      // Shift and field group; all three-operand
      d.cls = cls_shift;
      d.three_addr = 1'b1;
      d.size = size_of(op);
      case (op)
        8'hC0: d.fn = fn_arith_left_shift_word;
        8'hC4, 8'hC6, 8'hC7: d.fn = fn_arith_right_shift;
        8'hC8, 8'hCA, 8'hCB: begin
          d.cls = cls_logic;
          d.fn = fn_insert_field;
        end
        8'hCC, 8'hCE, 8'hCF: begin
          d.cls = cls_logic;
          d.fn = fn_extract_field;
        end
        8'hD0, 8'hD2, 8'hD3: d.fn = fn_logical_left_shift;
        8'hD4: d.fn = fn_logical_right_shift_word;
        8'hD8: d.fn = fn_rotate_word_op;
        8'hDB: begin
          d.cls = cls_bcd;
          d.size = sz_none;
          d.fn = fn_decimal_subtract_three;
        end
        default: d.fn = fn_none;
      endcase
    end else if (op[7]) begin
      // Two-address families, mirrored 0x40 higher in three-address form
      d.three_addr = op[6];
      d.size = size_of(op);
      d.cls = cls_arith;
      case (op[5:2])
        4'h0: begin
          d.cls = cls_move;
          d.fn = fn_clear;
        end
        4'h1: begin
          d.cls = cls_move;
          d.fn = fn_move;
        end
        4'h2: begin
          d.cls = cls_logic;
          d.fn = fn_complement;
        end
        4'h3: d.fn = fn_negate;
        4'h4: d.fn = fn_increment;
        4'h5: d.fn = fn_decrement;
        4'h6: begin
          d.size = sz_none;
          if (op[0]) begin
            d.cls = cls_bcd;
            d.fn = fn_decimal_subtract_two;
          end else begin
            d.cls = cls_system;
            d.fn = fn_quick_interrupt_exit;
          end
        end
        4'h7: d.fn = fn_add;
        4'h8: begin
          if (op[0]) begin
            d.cls = cls_bcd;
            d.size = sz_none;
            d.fn = op[6] ? fn_decimal_add_three : fn_decimal_add_two;
          end else begin
            d.cls = cls_move;
            d.fn = fn_push;
          end
        end
        4'h9: d.fn = fn_modulo;
        4'hA: d.fn = fn_multiply;
        4'hB: d.fn = fn_divide;
        4'hC: begin
          d.cls = cls_logic;
          d.fn = fn_or;
        end
        4'hD: begin
          d.cls = cls_logic;
          d.fn = fn_xor;
        end
        4'hE: begin
          d.cls = cls_logic;
          d.fn = fn_and;
        end
        default: d.fn = fn_subtract;
      endcase
    end else if (op[6]) begin
      // Returns, branches, test-decrement-branch and idle forms
      case (op[1:0])
        2'h0: begin
          if (op == COD_OP_IDLE_ONE) begin
            d.cls = cls_nop;
            d.fn = fn_idle;
          end else if (op == COD_OP_SUB_EXIT) begin
            d.cls = cls_branch;
            d.cond = cc_always;
            d.fn = fn_subroutine_exit;
          end else begin
            d.cls = cls_ret_cond;
            d.fn = fn_conditional_exit;
            d.cond = cond_of(op[5:2]);
          end
        end
        2'h1: begin
          d.cls = cls_tdb;
          d.fn = fn_count_test_branch;
          d.cond = tdb_cond(op[5:4]);
          d.disp = disp_byte;
        end
        default: begin
          if (op == COD_OP_IDLE_TWO || op == COD_OP_IDLE_THREE) begin
            d.cls = cls_nop;
            d.fn = fn_idle;
            d.span = (op == COD_OP_IDLE_TWO) ? COD_SPAN_TWO : COD_SPAN_THREE;
          end else begin
            d.cls = cls_branch;
            d.cond = cond_of(op[5:2]);
            d.fn = (op[5:2] == 4'hE) ? fn_jump_relative : fn_conditional_branch;
            d.disp = op[0] ? disp_byte : disp_half;
          end
        end
      endcase
    end else begin
      case (op)
        8'h02, 8'h06, 8'h22: begin
          d.cls = cls_coproc;
          d.fn = fn_cop_read;
        end
        8'h03, 8'h07, 8'h23: begin
          d.cls = cls_coproc;
          d.fn = fn_cop_two_addr;
        end
        8'h13, 8'h17, 8'h33: begin
          d.cls = cls_coproc;
          d.fn = fn_cop_write;
        end
        8'h32: begin
          d.cls = cls_coproc;
          d.fn = fn_coprocessor_generic_op;
        end
        8'h04: begin
          d.cls = cls_move;
          d.fn = fn_move_address;
        end
        8'h08: d.fn = fn_procedure_return;
        8'h09: begin
          d.cls = cls_interlock;
          d.fn = fn_compare_swap_locked;
          d.size = sz_word;
        end
        8'h1C, 8'h1E, 8'h1F: begin
          d.cls = cls_interlock;
          d.fn = fn_word_exchange_locked;
          d.size = size_of(op);
        end
        8'h0A, 8'h0B: d.fn = fn_x_flag;
        8'h0C: begin
          d.cls = cls_system;
          d.fn = fn_translated_word_move;
        end
        8'h0D, 8'h1D, 8'h2D, 8'h3D: begin
          d.cls = cls_tdb;
          d.fn = fn_count_test_branch;
          d.cond = tdb_cond(op[5:4]);
          d.disp = disp_half;
        end
        8'h0E, 8'h0F: begin
          d.cls = cls_bcd;
          d.fn = op[0] ? fn_decimal_expand : fn_decimal_compress;
        end
        8'h10: d.fn = fn_reg_save;
        8'h18: d.fn = fn_reg_restore;
        8'h14: d.fn = fn_extended;
        8'h19, 8'h29: begin
          d.cls = cls_branch;
          d.fn = fn_count_down_branch;
          d.disp = op[5] ? disp_byte : disp_half;
        end
        8'h20: begin
          d.cls = cls_move;
          d.fn = fn_pop;
        end
        8'h24: begin
          d.cls = cls_branch;
          d.cond = cc_always;
          d.fn = fn_jump;
        end
        8'h27: d.fn = fn_cache_flush;
        8'h28, 8'h2A, 8'h2B, 8'h3C, 8'h3E, 8'h3F: begin
          d.cls = cls_arith;
          d.fn = op[4] ? fn_compare : fn_test;
          d.size = size_of(op);
        end
        8'h38, 8'h3A, 8'h3B: begin
          d.cls = cls_logic;
          d.fn = fn_bit_test;
          d.size = size_of(op);
        end
        8'h2C: d.fn = fn_procedure_call;
        8'h2E: d.fn = fn_breakpoint;
        8'h2F: begin
          d.cls = cls_system;
          d.fn = fn_wait_interrupt;
        end
        8'h34, 8'h36, 8'h37: begin
          d.cls = cls_branch;
          d.cond = cc_always;
          d.fn = op[1] ? fn_subroutine_branch : fn_subroutine_call;
          d.disp = op[1] ? (op[0] ? disp_byte : disp_half) : disp_none;
        end
        default: d.fn = fn_none;
      endcase
    end
    d.priv = (op == COD_OP_TRANSLATED_MOVE) || (op == COD_OP_WAIT)
          || (op == COD_OP_QUICK_EXIT);
    d.illegal = !COD_LEGAL_MAP[op];
    if (d.illegal) begin
      d.cls = cls_illegal;
      d.fn = fn_none;
      d.priv = 1'b0;
    end
    return d;
  endfunction : decode_single

  ////////////////////////////////////////////////////////////////////////////////
  // Escape sequencing and output stage

  typedef enum logic {st_first, st_second} cod_state_t;

  cod_state_t state;
  cod_state_t next_state;
  cod_dec_t single_dec;
  cod_dec_t ext_dec;
  cod_dec_t next_out;
  wire logic take = fetch_valid && !fetch_flush;
  wire logic take_prefix = take && state == st_first && fetch_byte == COD_PREFIX;

  assign single_dec = decode_single(fetch_byte);

  cod_ext_decode u_ext (
    .second_byte(fetch_byte),
    .ext_dec(ext_dec)
  );

  // A flush drops a pending escape so a redirected stream starts clean
  always_comb begin
    next_state = state;
    case (state)
      st_first: next_state = take_prefix ? st_second : st_first;
      st_second: next_state = (take || fetch_flush) ? st_first : st_second;
      default: next_state = st_first;
    endcase
  end

  always_comb begin
    next_out = (state == st_second) ? ext_dec : single_dec;
    next_out.valid = take && !take_prefix;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= st_first;
      decode_out <= '0;
    end else begin
      state <= next_state;
      decode_out <= next_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence first_s(logic [7:0] v);
    take && state == st_first && fetch_byte == v;
  endsequence

  sequence escaped_s(logic [7:0] v);
    first_s(COD_PREFIX) ##1 (take && fetch_byte == v);
  endsequence

  idle_span_a: assert property (@(posedge core_clk) disable iff (!resetn)
    first_s(COD_OP_IDLE_THREE) |=> decode_out.valid && decode_out.cls == cls_nop
      && decode_out.span == COD_SPAN_THREE)
    else $error("three byte idle decoded wrongly");

  version_escape_a: assert property (@(posedge core_clk) disable iff (!resetn)
    escaped_s(COD_X_VERSION) |-> ##1 decode_out.valid && decode_out.prefixed
      && decode_out.fn == fn_read_version_number && !decode_out.priv)
    else $error("escaped version opcode decoded wrongly");

  escape_silent_a: assert property (@(posedge core_clk) disable iff (!resetn)
    first_s(COD_PREFIX) |=> !decode_out.valid)
    else $error("escape byte produced an operation");

  ack_priv_a: assert property (@(posedge core_clk) disable iff (!resetn)
    escaped_s(COD_X_INT_ACK) |-> ##1 decode_out.priv
      && decode_out.fn == fn_interrupt_acknowledge_op)
    else $error("interrupt acknowledge not privileged");

  single_priv_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (first_s(COD_OP_TRANSLATED_MOVE) or first_s(COD_OP_WAIT) or first_s(COD_OP_QUICK_EXIT))
      |=> decode_out.valid && decode_out.priv && decode_out.cls == cls_system)
    else $error("operating system opcode not flagged");

  carry_exit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    first_s(8'h50) |=> decode_out.cls == cls_ret_cond && decode_out.cond == cc_carry_clear)
    else $error("carry clear return decoded wrongly");

  unequal_exit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (first_s(8'h64) or first_s(8'h74)) |=> decode_out.cls == cls_ret_cond
      && decode_out.cond == cc_ne)
    else $error("unequal return aliases differ");

  equal_branch_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (first_s(8'h6E) or first_s(8'h7E)) |=> decode_out.cls == cls_branch
      && decode_out.cond == cc_eq && decode_out.disp == disp_half)
    else $error("equal branch aliases differ");

  illegal_op_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (take && state == st_first && !COD_LEGAL_MAP[fetch_byte])
      |=> decode_out.valid && decode_out.illegal && decode_out.cls == cls_illegal)
    else $error("unassigned opcode not reported illegal");

  xor_size_a: assert property (@(posedge core_clk) disable iff (!resetn)
    first_s(8'hF6) |=> decode_out.fn == fn_xor && decode_out.size == sz_half
      && decode_out.three_addr)
    else $error("three address xor halfword decoded wrongly");

endmodule : cod_decoder
`default_nettype wire

// [verif/cod_fetch_model.sv]
// Instruction fetch model that feeds opcode bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module cod_fetch_model (
  input wire logic core_clk,
  output logic fetch_valid,
  output logic [7:0] fetch_byte,
  output logic fetch_flush
);
  initial begin
    fetch_valid = 1'b0;
    fetch_byte = 8'h00;
    fetch_flush = 1'b0;
  end
  // Change at the falling edge so the decoder samples settled bytes
  task automatic put(input logic [7:0] b, input logic f);
    @(negedge core_clk);
    fetch_valid = 1'b1;
    fetch_byte = b;
    fetch_flush = f;
  endtask : put
  // An idle bus shows the inverse of the last byte, never a stale copy
  task automatic idle();
    @(negedge core_clk);
    fetch_valid = 1'b0;
    fetch_flush = 1'b0;
    fetch_byte = ~fetch_byte;
  endtask : idle
endmodule : cod_fetch_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench of the primary opcode decoder
`timescale 1ns/1ps
`default_nettype none
module tb
  import cod_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic fetch_valid;
  logic [7:0] fetch_byte;
  logic fetch_flush;
  cod_dec_t decode_out;
  cod_dec_t d;
  int num_errors = 0;
  int checked = 0;
  always #25 core_clk = ~core_clk;
  cod_fetch_model u_cod_fetch_model (.core_clk(core_clk), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .fetch_flush(fetch_flush));
  cod_decoder u_cod_decoder (.core_clk(core_clk), .resetn(resetn), .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte), .fetch_flush(fetch_flush), .decode_out(decode_out));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Leaves the byte up, so consecutive calls feed the decoder back to back
  task automatic dec(input logic [7:0] b, input logic f = 1'b0);
    u_cod_fetch_model.put(b, f);
    @(posedge core_clk);
    #1 d = decode_out;
  endtask : dec
  task automatic br(input logic [7:0] b, input cod_class_t c, input cod_cond_t cc,
    input cod_disp_t dp);
    dec(b);
    chk("valid", 16'h0001, 16'(d.valid));
    chk("cls", 16'(c), 16'(d.cls));
    chk("cond", 16'(cc), 16'(d.cond));
    chk("disp", 16'(dp), 16'(d.disp));
  endtask : br
  task automatic fam(input logic [7:0] b, input cod_class_t c, input cod_size_t sz,
    input logic ta);
    dec(b);
    chk("cls", 16'(c), 16'(d.cls));
    chk("size", 16'(sz), 16'(d.size));
    chk("three", 16'(ta), 16'(d.three_addr));
    chk("legal", 16'h0000, 16'(d.illegal));
  endtask : fam
  task automatic fnc(input logic [7:0] b, input cod_fn_t f);
    dec(b);
    chk("fn", 16'(f), 16'(d.fn));
    chk("op", {8'h00, b}, d.opcode);
  endtask : fnc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_escape();
    logic [7:0] xb [12] = '{8'h09, 8'h0D, 8'h13, 8'h19, 8'h1F, 8'h2F, 8'h35, 8'h45,
      8'h61, 8'hAC, 8'hC0, 8'hC8};
    cod_fn_t xf [12] = '{fn_read_version_number, fn_virtual_pin_on_jump,
      fn_virtual_pin_off_jump, fn_block_word_copy, fn_string_terminator_find,
      fn_interrupt_acknowledge_op, fn_string_copy_op, fn_gate_exit, fn_gate_enter,
      fn_process_invoke, fn_user_process_invoke, fn_process_resume};
    logic [11:0] xp = 12'hFA6;
    foreach (xb[i]) begin
      dec(COD_PREFIX);
      chk("esc_valid", 16'h0000, 16'(d.valid));
      // The second pair has a gap: the escape must wait for its second byte
      if (i == 1) u_cod_fetch_model.idle();
      dec(xb[i]);
      chk("x_fn", 16'(xf[i]), 16'(d.fn));
      chk("x_priv", 16'(xp[i]), 16'(d.priv));
      chk("x_op", {COD_PREFIX, xb[i]}, d.opcode);
      chk("x_span", 16'(COD_SPAN_TWO), 16'(d.span));
    end
  endtask : t_escape
  task automatic t_idle();
    logic [7:0] nb [3] = '{8'h70, 8'h73, 8'h72};
    foreach (nb[i]) begin
      dec(nb[i]);
      chk("nop_cls", 16'(cls_nop), 16'(d.cls));
      chk("nop_span", 16'(i + 1), 16'(d.span));
    end
  endtask : t_idle
  task automatic t_branch();
    br(8'h50, cls_ret_cond, cc_carry_clear, disp_none);
    br(8'h52, cls_branch, cc_carry_clear, disp_half);
    br(8'h53, cls_branch, cc_carry_clear, disp_byte);
    br(8'h5A, cls_branch, cc_carry_set, disp_half);
    br(8'h58, cls_ret_cond, cc_carry_set, disp_none);
    br(8'h6E, cls_branch, cc_eq, disp_half);
    br(8'h7F, cls_branch, cc_eq, disp_byte);
    br(8'h66, cls_branch, cc_ne, disp_half);
    br(8'h77, cls_branch, cc_ne, disp_byte);
    br(8'h64, cls_ret_cond, cc_ne, disp_none);
    br(8'h74, cls_ret_cond, cc_ne, disp_none);
    br(8'h6C, cls_ret_cond, cc_eq, disp_none);
    br(8'h7C, cls_ret_cond, cc_eq, disp_none);
    br(8'h44, cls_ret_cond, cc_gt, disp_none);
    br(8'h5C, cls_ret_cond, cc_leu, disp_none);
    br(8'h4B, cls_branch, cc_lt, disp_byte);
    br(8'h4E, cls_branch, cc_le, disp_half);
    br(8'h56, cls_branch, cc_gtu, disp_half);
    br(8'h5F, cls_branch, cc_leu, disp_byte);
    br(8'h63, cls_branch, cc_ovf_clear, disp_byte);
    br(8'h6A, cls_branch, cc_ovf_set, disp_half);
    br(8'h7A, cls_branch, cc_always, disp_half);
    br(8'h4D, cls_tdb, cc_eq, disp_byte);
    br(8'h0D, cls_tdb, cc_eq, disp_half);
    br(8'h7D, cls_tdb, cc_ne, disp_byte);
  endtask : t_branch
  task automatic t_family();
    fam(8'h1E, cls_interlock, sz_half, 1'b0);
    fam(8'h1F, cls_interlock, sz_byte, 1'b0);
    fam(8'hC7, cls_shift, sz_byte, 1'b1);
    fam(8'hD2, cls_shift, sz_half, 1'b1);
    fam(8'hB6, cls_logic, sz_half, 1'b0);
    fam(8'hF7, cls_logic, sz_byte, 1'b1);
    fam(8'hF6, cls_logic, sz_half, 1'b1);
    fam(8'h9E, cls_arith, sz_half, 1'b0);
    fam(8'hDC, cls_arith, sz_word, 1'b1);
    fnc(8'h1C, fn_word_exchange_locked);
    fnc(8'h32, fn_coprocessor_generic_op);
    fnc(8'h02, fn_cop_read);
    fnc(8'h17, fn_cop_write);
    fnc(8'h23, fn_cop_two_addr);
    fnc(8'hD8, fn_rotate_word_op);
    fnc(8'hD4, fn_logical_right_shift_word);
    fnc(8'hDB, fn_decimal_subtract_three);
    fnc(8'h0F, fn_decimal_expand);
    fnc(COD_OP_TRANSLATED_MOVE, fn_translated_word_move);
    chk("priv", 16'h0001, 16'(d.priv));
    fnc(COD_OP_QUICK_EXIT, fn_quick_interrupt_exit);
    chk("priv", 16'h0001, 16'(d.priv));
  endtask : t_family
  task automatic t_fault();
    dec(8'h00);
    chk("ill", 16'h0001, 16'(d.illegal & d.valid));
    chk("ill_cls", 16'(cls_illegal), 16'(d.cls));
    dec(COD_PREFIX);
    dec(COD_PREFIX);
    chk("ill_x", 16'h0001, 16'(d.illegal & d.prefixed));
    dec(COD_PREFIX);
    dec(8'h09, 1'b1);
    chk("fl_valid", 16'h0000, 16'(d.valid));
    dec(COD_OP_IDLE_ONE);
    chk("fl_span", 16'(COD_SPAN_ONE), 16'(d.span));
    dec(COD_PREFIX);
    u_cod_fetch_model.idle();
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    // Reset must have dropped the pending escape
    fnc(8'h09, fn_compare_swap_locked);
  endtask : t_fault
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    t_escape();
    t_idle();
    t_branch();
    t_family();
    t_fault();
    summarize();
  end
  // The tests need well under 200 cycles; this margin only catches a hang
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule : tb
`default_nettype wire
